// *** flash_wcs_defs.svh ***
// Offsets, field positions, reset values and codes of the flash write control.
`ifndef FLASH_WCS_DEFS_SVH
`define FLASH_WCS_DEFS_SVH
`define RA_BASE_HI 19'h07000
`define RA_CSL 5'h00
`define RA_CSH 5'h02
`define RA_SECL 5'h04
`define RA_SECH 5'h06
`define RA_D0L 5'h08
`define RA_D0H 5'h0a
`define RA_D1L 5'h0c
`define RA_D1H 5'h0e
`define RA_ADL 5'h10
`define RA_ADH 5'h12
`define RA_ERR 5'h14
`define RST_VAL 16'h0000
`define BIT_BUSY1 6
`define BIT_BUSY0 5
`define BIT_LOCK 4
`define BIT_BUSY3 2
`define BIT_BUSY2 1
`define BIT_WS 15
`define BIT_WPG 13
`define BIT_DWPG 12
`define BIT_SER 11
`define BIT_SPR 8
`define BIT_MODULE_SELECT 7
`define CSH_MODE_MASK 16'h3980
`define BIT_ERR_SEQ 0
`define TRAP_INVALID 16'h009b
`define INVALID_DATA 16'hffff
`define TEST_END 24'h001fff
`define BANK1_W 24'h070000
`define BANK3_W 24'h0c0000
`define BANK0_R 24'h000000
`define BANK1_R 24'h070000
`define BANK2_R 24'h090000
`define BANK3_R 24'h0c0000
`define FLASH_END 24'h0e0000
`define SEC_B0_MASK 32'h000003ff
`define SEC_B2_MASK 32'h00070000
`endif

// *** flash_wcs_pkg.sv ***
// Types shared by the flash write control modules.
package flash_wcs_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_SUSP} op_state_e;
	typedef enum logic [1:0] {OP_WPG, OP_DWPG, OP_SER, OP_SPR} op_kind_e;
	typedef logic [1:0] bank_t;
endpackage

// *** flash_bank_guard.sv ***
// Per-bank check of array accesses against the bank busy flags.
`include "flash_wcs_defs.svh"
module flash_bank_guard
	import flash_wcs_pkg::*;
(
	// Array access
	input wire logic [23:0] addr,
	input wire logic rd,
	input wire logic wr,
	// Bank state
	input wire logic [3:0] busy,
	// Verdict
	output logic rd_trap,
	output logic wr_block
);
	localparam logic [23:0] LO [5] = '{`BANK0_R, `BANK1_R, `BANK2_R,
		`BANK3_R, `FLASH_END};
	logic [3:0] hit;

	// Each bank has its own sensing, so only the busy bank is fenced off.
	for (genvar i = 0; i < 4; i++) begin : g_bank
		assign hit[i] = busy[i] && addr >= LO[i] && addr < LO[i + 1];
	end

	assign rd_trap = rd && |hit;
	assign wr_block = wr && |hit;
endmodule // flash_bank_guard

// *** flash_target_bank.sv ***
// Works out which bank an operation modifies and spots the test sector.
`include "flash_wcs_defs.svh"
module flash_target_bank
	import flash_wcs_pkg::*;
(
	// Operation setup
	input wire logic module_select,
	input wire logic sector_erase_select,
	input wire logic set_protection_select,
	input wire logic [23:0] addr,
	input wire logic [31:0] sectors,
	// Result
	output bank_t bank,
	output logic test_hit
);
	always_comb begin
		if (set_protection_select) begin
			bank = 2'd2;
		end else if (sector_erase_select) begin
			if (module_select) begin
				bank = |(sectors & `SEC_B0_MASK) ? 2'd0 : 2'd1;
			end else begin
				bank = |(sectors & `SEC_B2_MASK) ? 2'd2 : 2'd3;
			end
		end else if (module_select) begin
			bank = addr < `BANK1_W ? 2'd0 : 2'd1;
		end else begin
			bank = addr < `BANK3_W ? 2'd2 : 2'd3;
		end
	end

	// Program writes to the low segment land in the reserved test sector.
	assign test_hit = module_select && !sector_erase_select && !set_protection_select && addr <= `TEST_END;
endmodule // flash_target_bank

// *** flash_write_control_status.sv ***
// Register interface, lock and busy control of the flash write sequencer.
`include "flash_wcs_defs.svh"
// Behaviour
// - Registers sit in the byte range 0x0E0000 to 0x0E0015.
// - Four 16-bit control registers plus address, data and error registers.
// - Every register takes byte and halfword reads; all but the low status register take byte and halfword writes.
// - Banks sense independently; other banks read normally during a write.
// - Only one program or erase runs at a time across the flash.
// - Reading the bank under modification gives invalid data and trap 009Bh.
// - A core supply drop aborts the operation and returns to read mode.
// - User writes to the bank 0 test sector are rejected.
// - Test sector is visible only in bootstrap mode.
// - Per-bank busy flags set when the write-start bit is set; their status bits still read 0, being copied only while unlocked.
// - Set-protection marks bank 2 busy.
// - Busy bank reads trap with invalid data; writes are ignored.
// - Busy clears on finish or suspend and sets again on resume.
// - While locked, reads of all but the low status register trap and register writes do nothing.
// - Lock sets as soon as the write-start bit is set.
// - Lock stays readable at all times; low lock opens the registers.
// - Error register updates only once all busy flags are clear.
// - Module select steers the operation and clears when it ends.
// - Word program writes one 32-bit word from the first data pair.
// - Sector erase sets selected sectors to 0xFF with pre-programming.
module flash_write_control_status
	import flash_wcs_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Register port
	input wire logic [23:0] reg_addr,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [1:0] reg_be,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic reg_trap,
	// Array access port
	input wire logic [23:0] arr_addr,
	input wire logic arr_rd,
	input wire logic arr_wr,
	output logic arr_trap,
	output logic arr_wr_ignored,
	output logic [15:0] trap_code,
	// System
	input wire logic bootstrap_mode,
	input wire logic supply_low,
	output logic test_sector_visible,
	// Program/erase core
	output logic core_start,
	output logic core_resume,
	output logic core_abort,
	output op_kind_e core_kind,
	output logic core_module,
	output bank_t core_bank,
	output logic [23:0] core_addr,
	output logic [31:0] core_data0,
	output logic [31:0] core_data1,
	output logic [31:0] core_sectors,
	input wire logic core_done,
	input wire logic core_suspended,
	input wire logic [15:0] core_err
);
	op_state_e state_r;
	bank_t bank_r;
	logic [15:0] csh_r, err_r;
	logic [31:0] sec_r, d0_r, d1_r;
	logic [23:0] adr_r;
	logic [4:0] off;
	logic hit, wr_acc, rd_acc, lock, start_req, legal, test_hit, abort;
	logic rd_trap, wr_block;
	logic [3:0] busy;
	logic [15:0] status, rmux;
	bank_t tgt_bank;

	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [15:0] wd, input logic [1:0] be);
		merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	// Decode: byte address within the 0x0E0000 window, halfword granular.
	assign off = {reg_addr[4:1], 1'b0};
	assign hit = reg_addr[23:5] == `RA_BASE_HI && off <= `RA_ERR;
	assign lock = state_r == ST_BUSY;
	// Only reads of the low status register escape the lock; every register write is blocked.
	assign wr_acc = reg_wr && hit && !lock;
	assign rd_acc = reg_rd && hit;
	assign busy = lock ? 4'(1 << bank_r) : 4'h0;
	assign abort = supply_low && state_r != ST_IDLE;
	assign start_req = wr_acc && off == `RA_CSH && reg_be[1] &&
		reg_wdata[`BIT_WS];
	assign legal = $onehot({csh_r[`BIT_WPG], csh_r[`BIT_DWPG],
		csh_r[`BIT_SER], csh_r[`BIT_SPR]}) && !test_hit;

	flash_target_bank u_target (
		.module_select(csh_r[`BIT_MODULE_SELECT]),
		.sector_erase_select(csh_r[`BIT_SER]),
		.set_protection_select(csh_r[`BIT_SPR]),
		.addr(adr_r),
		.sectors(sec_r),
		.bank(tgt_bank),
		.test_hit(test_hit)
	);

	flash_bank_guard u_guard (
		.addr(arr_addr),
		.rd(arr_rd),
		.wr(arr_wr),
		.busy(busy),
		.rd_trap(rd_trap),
		.wr_block(wr_block)
	);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_r <= ST_IDLE;
		end else if (abort) begin
			state_r <= ST_IDLE;
		end else begin
			unique case (state_r)
				ST_IDLE: if (start_req && legal) begin
					state_r <= ST_BUSY;
				end
				ST_BUSY: if (core_done) begin
					state_r <= ST_IDLE;
				end else if (core_suspended) begin
					state_r <= ST_SUSP;
				end
				ST_SUSP: if (start_req) begin
					state_r <= ST_BUSY;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			bank_r <= 2'd0;
		end else if (state_r == ST_IDLE && start_req) begin
			bank_r <= tgt_bank;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			core_start <= 1'b0;
			core_resume <= 1'b0;
			core_abort <= 1'b0;
		end else begin
			core_start <= state_r == ST_IDLE && start_req && legal;
			core_resume <= state_r == ST_SUSP && start_req && !abort;
			core_abort <= abort;
		end
	end

	// Mode bits clear themselves once the operation is over.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			csh_r <= `RST_VAL;
		end else if (abort || (lock && core_done)) begin
			csh_r <= `RST_VAL;
		end else if (wr_acc && off == `RA_CSH && state_r == ST_IDLE) begin
			csh_r <= merge(csh_r, reg_wdata, reg_be) & `CSH_MODE_MASK;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sec_r <= {`RST_VAL, `RST_VAL};
			d0_r <= {`RST_VAL, `RST_VAL};
			d1_r <= {`RST_VAL, `RST_VAL};
			adr_r <= 24'h000000;
		end else if (wr_acc) begin
			unique case (off)
				`RA_SECL: sec_r[15:0] <= merge(sec_r[15:0], reg_wdata, reg_be);
				`RA_SECH: sec_r[31:16] <= merge(sec_r[31:16], reg_wdata, reg_be);
				`RA_D0L: d0_r[15:0] <= merge(d0_r[15:0], reg_wdata, reg_be);
				`RA_D0H: d0_r[31:16] <= merge(d0_r[31:16], reg_wdata, reg_be);
				`RA_D1L: d1_r[15:0] <= merge(d1_r[15:0], reg_wdata, reg_be);
				`RA_D1H: d1_r[31:16] <= merge(d1_r[31:16], reg_wdata, reg_be);
				`RA_ADL: adr_r[15:0] <= merge(adr_r[15:0], reg_wdata, reg_be);
				`RA_ADH: adr_r[23:16] <= reg_be[0] ? reg_wdata[7:0] : adr_r[23:16];
				default: ;
			endcase
		end
	end

	// Capture happens as busy drops, so it wins over a host write.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			err_r <= `RST_VAL;
		end else if (lock && core_done) begin
			err_r <= core_err;
		end else if (state_r == ST_IDLE && start_req && !legal) begin
			err_r[`BIT_ERR_SEQ] <= 1'b1;
		end else if (wr_acc && off == `RA_ERR) begin
			err_r <= merge(err_r, reg_wdata, reg_be);
		end
	end

	always_comb begin
		status = `RST_VAL;
		status[`BIT_LOCK] = lock;
		if (!lock) begin
			status[`BIT_BUSY0] = busy[0];
			status[`BIT_BUSY1] = busy[1];
			status[`BIT_BUSY2] = busy[2];
			status[`BIT_BUSY3] = busy[3];
		end
		unique case (off)
			`RA_CSL: rmux = status;
			`RA_CSH: rmux = csh_r;
			`RA_SECL: rmux = sec_r[15:0];
			`RA_SECH: rmux = sec_r[31:16];
			`RA_D0L: rmux = d0_r[15:0];
			`RA_D0H: rmux = d0_r[31:16];
			`RA_D1L: rmux = d1_r[15:0];
			`RA_D1H: rmux = d1_r[31:16];
			`RA_ADL: rmux = adr_r[15:0];
			`RA_ADH: rmux = {8'h00, adr_r[23:16]};
			default: rmux = err_r;
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= `RST_VAL;
			reg_trap <= 1'b0;
		end else if (rd_acc && lock && off != `RA_CSL) begin
			reg_rdata <= `INVALID_DATA;
			reg_trap <= 1'b1;
		end else begin
			reg_rdata <= rd_acc ? rmux : `RST_VAL;
			reg_trap <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			arr_trap <= 1'b0;
			arr_wr_ignored <= 1'b0;
			trap_code <= `RST_VAL;
			test_sector_visible <= 1'b0;
		end else begin
			arr_trap <= rd_trap;
			arr_wr_ignored <= wr_block;
			trap_code <= (rd_trap || (rd_acc && lock && off != `RA_CSL)) ?
				`TRAP_INVALID : `RST_VAL;
			test_sector_visible <= bootstrap_mode;
		end
	end

	// The core gets word data from the first pair, double words from both.
	assign core_kind = csh_r[`BIT_SPR] ? OP_SPR : csh_r[`BIT_SER] ? OP_SER :
		csh_r[`BIT_DWPG] ? OP_DWPG : OP_WPG;
	assign core_module = csh_r[`BIT_MODULE_SELECT];
	assign core_bank = bank_r;
	assign core_addr = adr_r;
	assign core_data0 = d0_r;
	assign core_data1 = d1_r;
	assign core_sectors = sec_r;

	lock_on_start_a: assert property (@(posedge clock) disable iff (!resetn)
		state_r == ST_IDLE && start_req && legal && !abort |=> lock)
		else $error("lock not set after start");
	one_op_a: assert property (@(posedge clock) disable iff (!resetn)
		lock && !core_done && !core_suspended && !abort |=> lock && $stable(bank_r))
		else $error("operation changed while running");
	abort_clears_a: assert property (@(posedge clock) disable iff (!resetn)
		abort |=> !lock && busy == 4'h0 && core_abort && csh_r == `RST_VAL)
		else $error("abort left flags set");
	locked_read_a: assert property (@(posedge clock) disable iff (!resetn)
		rd_acc && lock && off != `RA_CSL |=> reg_trap &&
		reg_rdata == `INVALID_DATA && trap_code == `TRAP_INVALID)
		else $error("locked read not trapped");
	locked_write_a: assert property (@(posedge clock) disable iff (!resetn)
		lock && !core_done && !abort |=> $stable(d0_r) && $stable(adr_r))
		else $error("register changed under lock");
	busy_read_a: assert property (@(posedge clock) disable iff (!resetn)
		arr_rd && busy[bank_r] && arr_addr >= `BANK2_R && arr_addr < `BANK3_R &&
		bank_r == 2'd2 |=> arr_trap)
		else $error("busy bank read not trapped");
	test_reject_a: assert property (@(posedge clock) disable iff (!resetn)
		state_r == ST_IDLE && start_req && test_hit |=> state_r == ST_IDLE &&
		err_r[`BIT_ERR_SEQ])
		else $error("test sector write started");
	suspend_a: assert property (@(posedge clock) disable iff (!resetn)
		lock && core_suspended && !core_done && !abort |=> busy == 4'h0 ##0
		state_r == ST_SUSP)
		else $error("busy kept during suspend");
	err_capture_a: assert property (@(posedge clock) disable iff (!resetn)
		lock && core_done && !abort |=> err_r == $past(core_err) && busy == 4'h0)
		else $error("error register not captured");
	lock_visible_a: assert property (@(posedge clock) disable iff (!resetn)
		rd_acc && off == `RA_CSL |=> !reg_trap &&
		reg_rdata[`BIT_LOCK] == $past(lock))
		else $error("lock bit unreadable");
endmodule // flash_write_control_status

// *** pe_core_model.sv ***
// Behavioural program/erase core that answers the flash write control block.
module pe_core_model #(
	parameter int DELAY = 30,
	parameter logic [15:0] ERR = 16'h0040
) (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Commands from the block
	input wire logic start,
	input wire logic resume,
	input wire logic abort,
	input wire logic susp_req,
	// Status to the block
	output logic done,
	output logic suspended,
	output logic [15:0] err
);
	logic run_r;
	int cnt_r;
	// A suspend is only reported while an operation really runs.
	assign suspended = susp_req && run_r;
	assign err = ERR;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			run_r <= 1'b0;
			cnt_r <= 0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start)
				cnt_r <= 0;
			if (start || resume)
				run_r <= 1'b1;
			else if (abort || suspended)
				run_r <= 1'b0;
			else if (run_r && cnt_r == DELAY) begin
				run_r <= 1'b0;
				done <= 1'b1;
			end else if (run_r)
				cnt_r <= cnt_r + 1;
		end
	end
endmodule // pe_core_model

// *** flash_write_control_status_tb_top.sv ***
// Self-checking bench for the flash write control and status block.
`include "flash_wcs_defs.svh"
module flash_write_control_status_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock, resetn, reg_rd, reg_wr, arr_rd, arr_wr;
	logic bootstrap_mode, supply_low, susp_req, reg_trap, arr_trap;
	logic arr_wr_ignored, tsv, core_start, core_resume, core_abort;
	logic core_done, core_suspended, core_module;
	logic [1:0] core_kind, core_bank;
	logic [23:0] core_addr;
	logic [31:0] core_data0, core_sectors;
	logic [23:0] reg_addr, arr_addr;
	logic [1:0] reg_be;
	logic [15:0] reg_wdata, reg_rdata, trap_code, core_err, v;
	int fail_count, n_compared;

	flash_write_control_status flash_write_control_status_inst (
		.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
		.reg_rd(reg_rd), .reg_wr(reg_wr), .reg_be(reg_be),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_trap(reg_trap),
		.arr_addr(arr_addr), .arr_rd(arr_rd), .arr_wr(arr_wr),
		.arr_trap(arr_trap), .arr_wr_ignored(arr_wr_ignored),
		.trap_code(trap_code), .bootstrap_mode(bootstrap_mode),
		.supply_low(supply_low), .test_sector_visible(tsv),
		.core_start(core_start), .core_resume(core_resume),
		.core_abort(core_abort), .core_kind(core_kind),
		.core_module(core_module), .core_bank(core_bank),
		.core_addr(core_addr), .core_data0(core_data0), .core_data1(),
		.core_sectors(core_sectors), .core_done(core_done),
		.core_suspended(core_suspended), .core_err(core_err));

	pe_core_model pe_core_model_inst (
		.clock(clock), .resetn(resetn), .start(core_start),
		.resume(core_resume), .abort(core_abort), .susp_req(susp_req),
		.done(core_done), .suspended(core_suspended), .err(core_err));

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask

	task automatic wr(input logic [4:0] off, input logic [15:0] d,
		input logic [1:0] be = 2'b11);
		@(posedge clock);
		#1;
		reg_addr = {`RA_BASE_HI, off};
		reg_wdata = d;
		reg_be = be;
		reg_wr = 1'b1;
		@(posedge clock);
		#1;
		reg_wr = 1'b0;
	endtask

	task automatic rd(input logic [4:0] off, output logic [15:0] d);
		@(posedge clock);
		#1;
		reg_addr = {`RA_BASE_HI, off};
		reg_be = 2'b11;
		reg_rd = 1'b1;
		@(posedge clock);
		#1;
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask

	task automatic arr(input logic [23:0] a, input logic w);
		@(posedge clock);
		#1;
		arr_addr = a;
		arr_rd = !w;
		arr_wr = w;
		@(posedge clock);
		#1;
		arr_rd = 1'b0;
		arr_wr = 1'b0;
	endtask

	// Mode bits go in first; the start bit then launches them together.
	task automatic go(input logic [15:0] mode);
		wr(`RA_CSH, mode);
		wr(`RA_CSH, mode | 16'h8000);
	endtask

	// Polls the lock flag with a bounded count, as a host would.
	task automatic wait_idle();
		for (int i = 0; i < 200; i++) begin
			rd(`RA_CSL, v);
			if (v[`BIT_LOCK] === 1'b0)
				break;
		end
		chk(v, 16'h0000);
	endtask

	task automatic tally_and_finish();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		#100000;
		fail_count++;
		tally_and_finish();
	end

	initial begin
		{reg_rd, reg_wr, arr_rd, arr_wr, susp_req} = '0;
		{bootstrap_mode, supply_low} = '0;
		reg_addr = '0;
		arr_addr = '0;
		reg_be = 2'b11;
		reg_wdata = '0;
		fail_count = 0;
		n_compared = 0;
		resetn = 1'b0;
		repeat (10) @(posedge clock);
		#1;
		// The extension enables are taken as set, so registers answer at once.
		resetn = 1'b1;
		rd(`RA_CSL, v);
		chk(v, `RST_VAL);
		rd(5'h16, v);
		chk(v, 16'h0000);
		wr(`RA_D0L, 16'h1234, 2'b01);
		rd(`RA_D0L, v);
		chk(v, 16'h0034);
		wr(`RA_D0L, 16'hab00, 2'b10);
		rd(`RA_D0L, v);
		chk(v, 16'hab34);
		$display("test registers done");
		wr(`RA_ADL, 16'h0000);
		wr(`RA_ADH, 16'h0007);
		go(16'h2080);
		chk(16'(core_start), 16'h0001);
		chk(16'(core_kind), 16'(flash_wcs_pkg::OP_WPG));
		chk(16'(core_module), 16'h0001);
		chk(16'(core_bank), 16'h0001);
		chk(16'(core_addr[23:16]), 16'h0007);
		chk(core_data0[15:0], 16'hab34);
		rd(`RA_CSL, v);
		chk(v, 16'h0010);
		rd(`RA_D0L, v);
		chk(v, `INVALID_DATA);
		chk(16'(reg_trap), 16'h0001);
		chk(trap_code, `TRAP_INVALID);
		wr(`RA_D0L, 16'h5555);
		arr(`BANK1_R, 1'b0);
		chk(16'(arr_trap), 16'h0001);
		chk(trap_code, `TRAP_INVALID);
		arr(`BANK0_R, 1'b0);
		chk(16'(arr_trap), 16'h0000);
		arr(`BANK1_R, 1'b1);
		chk(16'(arr_wr_ignored), 16'h0001);
		wait_idle();
		rd(`RA_D0L, v);
		chk(v, 16'hab34);
		rd(`RA_ERR, v);
		chk(v, 16'h0040);
		rd(`RA_CSH, v);
		chk(v, 16'h0000);
		arr(`BANK1_R, 1'b0);
		chk(16'(arr_trap), 16'h0000);
		$display("test word program done");
		wr(`RA_ADH, 16'h0000);
		go(16'h2080);
		rd(`RA_CSL, v);
		chk(v, 16'h0000);
		rd(`RA_ERR, v);
		chk(16'(v[`BIT_ERR_SEQ]), 16'h0001);
		bootstrap_mode = 1'b1;
		repeat (2) @(posedge clock);
		#1;
		chk(16'(tsv), 16'h0001);
		$display("test test sector done");
		wr(`RA_ADL, 16'hdfb0);
		wr(`RA_ADH, 16'h000e);
		go(16'h0100);
		chk(16'(core_bank), 16'h0002);
		chk(16'(core_kind), 16'(flash_wcs_pkg::OP_SPR));
		arr(`BANK2_R, 1'b0);
		chk(16'(arr_trap), 16'h0001);
		arr(`BANK3_R, 1'b0);
		chk(16'(arr_trap), 16'h0000);
		wait_idle();
		$display("test set protection done");
		wr(`RA_SECH, 16'h0008);
		go(16'h0800);
		chk(16'(core_kind), 16'(flash_wcs_pkg::OP_SER));
		chk(core_sectors[31:16], 16'h0008);
		chk(16'(core_bank), 16'h0003);
		arr(`BANK3_R, 1'b0);
		chk(16'(arr_trap), 16'h0001);
		supply_low = 1'b1;
		@(posedge clock);
		#1;
		supply_low = 1'b0;
		chk(16'(core_abort), 16'h0001);
		rd(`RA_CSL, v);
		chk(v, 16'h0000);
		arr(`BANK3_R, 1'b0);
		chk(16'(arr_trap), 16'h0000);
		go(16'h0800);
		wait_idle();
		$display("test supply abort done");
		wr(`RA_ADL, 16'h0000);
		wr(`RA_ADH, 16'h0007);
		go(16'h2080);
		susp_req = 1'b1;
		// The core sees the start one edge late and reports suspend after it.
		repeat (3) @(posedge clock);
		#1;
		arr(`BANK1_R, 1'b0);
		chk(16'(arr_trap), 16'h0000);
		susp_req = 1'b0;
		rd(`RA_CSL, v);
		chk(v, 16'h0000);
		wr(`RA_CSH, 16'h8000);
		chk(16'(core_resume), 16'h0001);
		arr(`BANK1_R, 1'b0);
		chk(16'(arr_trap), 16'h0001);
		wait_idle();
		$display("test suspend resume done");
		tally_and_finish();
	end
endmodule // flash_write_control_status_tb_top
